// ===== hdl/dxt_pkg.sv
// Package for the inbound DMA address translator: constants and carriers
package dxt_pkg;

  // ----------------------------------------------------------------------
  // Address field positions
  // ----------------------------------------------------------------------
  localparam int DIRECT_BIT      = 31;
  localparam int PAGED_BIT       = 30;
  localparam int DIRECT_LO_W     = 31;
  localparam int DMAP_W          = 17;
  localparam int SYS_ADDR_W      = 50;
  localparam int DMAP_LSB        = 31;
  localparam int OFF4K_W         = 12;
  localparam int OFF16K_W        = 14;
  localparam int PAGE_HI         = 29;
  localparam int ATTR_HI         = 63;
  localparam int ATTR_LO         = 54;
  localparam int ATTR_W          = 10;
  localparam int WIDE_TGT_W      = 51;
  localparam int NODE_LSB        = 38;
  localparam int NODE_W          = 12;
  localparam int TE_IDX_W        = 18;
  localparam int TE_PFN_W        = 36;

  localparam logic [ATTR_W-1:0] ATTR_ALL_SET = 10'h3ff;
  localparam logic [DMAP_W-1:0] DMAP_RESET   = 17'h00000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DXT_KIND_DIRECT,
    DXT_KIND_PAGED,
    DXT_KIND_WIDE,
    DXT_KIND_BAD
  } dxt_kind_t;

  typedef struct packed {
    logic [63:0] addr;
    logic        dac;
    logic        wr;
    logic        consistent;
  } dxt_req_t;

  typedef struct packed {
    logic [SYS_ADDR_W-1:0] sys_addr;
    logic [ATTR_W-1:0]     attr;
    logic                  remote;
    logic                  wr;
    dxt_kind_t             kind;
  } dxt_out_t;

  typedef struct packed {
    logic [TE_PFN_W-1:0] pfn;
    logic [ATTR_W-1:0]   attr;
  } dxt_te_t;

endpackage : dxt_pkg

// ===== hdl/dxt_translator.sv
// Inbound DMA address translator and router for one PCI-X bus
// Functional notes
// - 32-bit address with bit 31 set is direct-mapped via direct map reg.
// - 32-bit address with bit 30 set and bit 31 clear is page-mapped via translation entry.
// - Direct-mapped: DMA bits 30..0 become system bits 30..0.
// - Direct-mapped: direct map bits 16..0 become system bits 47..31.
// - Direct map register is a 17-bit constant selecting a 2 GB window.
// - Exactly one direct map register per bus, shared by all requests.
// - 4 KB pages: offset bits 11..0, entry index bits 29..12.
// - 16 KB pages: offset bits 13..0, entry index bits 29..14.
// - Page-mapped upper address from entry; attributes from entry plus direct map.
// - Direct-mapped attributes from device registers and direct map.
// - 64-bit address with bits 63..54 set carries attributes there.
// - 64-bit address bits 49..0 are the system target directly.
// - Dual cycle with upper bits zero is handled as 32-bit address.
// - Wide devices: 64-bit for streaming, 32-bit for consistent mappings.
// - Every request except a refused one goes to the hub port; local memory completes local.
// - Requests for another node are marked remote for the interconnect.
// - Posted writes drain and complete before interrupt is forwarded.
// - Coherence is kept by hardware; no sync operation is exposed.
// - Posted writes drain as the hub reports each one done; a pending interrupt waits for them and blocks new requests.
`timescale 1ns/1ps

module dxt_translator
  import dxt_pkg::*;
#(
  parameter int POST_DEPTH = 4
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // DMA request from the PCI-X side
  input  wire logic                  req_valid,
  output      logic                  req_ready,
  input  wire dxt_pkg::dxt_req_t     req,
  // Per-bus configuration
  input  wire logic [dxt_pkg::DMAP_W-1:0] dmap_value,
  input  wire logic                  dmap_load,
  input  wire logic                  page_16k,
  input  wire logic [dxt_pkg::ATTR_W-1:0] dev_attr,
  input  wire logic [dxt_pkg::NODE_W-1:0] local_node,
  // Translation entry lookup (combinational table outside)
  output      logic [dxt_pkg::TE_IDX_W-1:0] te_index,
  input  wire dxt_pkg::dxt_te_t      te_data,
  // Hub I/O interface
  output      logic                  hub_valid,
  input  wire logic                  hub_ready,
  output      dxt_pkg::dxt_out_t     hub_req,
  input  wire logic                  hub_wr_done,
  // Interrupt path
  input  wire logic                  dev_irq,
  output      logic                  cpu_irq,
  // Status
  output      logic                  xlate_err,
  output      logic                  wide_no_dac_err,
  output      logic [dxt_pkg::DMAP_W-1:0] dmap_q_out
);
  import dxt_pkg::*;

  // ----------------------------------------------------------------------
  // Direct map register, one for the whole bus
  // ----------------------------------------------------------------------
  logic [DMAP_W-1:0] dmap_q;

  always_ff @(posedge clk) begin
    if (!resetn) dmap_q <= DMAP_RESET;
    else if (dmap_load) dmap_q <= dmap_value;
  end
  assign dmap_q_out = dmap_q;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire        upper_zero = (req.addr[63:32] == 32'h0000_0000);
  wire        is32       = !req.dac || upper_zero;
  wire        bit_dir    = req.addr[DIRECT_BIT];
  wire        bit_pag    = req.addr[PAGED_BIT];
  wire        wide_attr  = (req.addr[ATTR_HI:ATTR_LO] == ATTR_ALL_SET);
  // A 64-bit address arriving in a single cycle is decoded from its low 32
  // bits alone; wide_no_dac_err flags it when the attribute field is set.
  wire        wide_ok    = req.dac && !upper_zero && wide_attr;
  wire        no_dac     = 1'b0;
  dxt_kind_t  kind;

  assign kind = (is32 && bit_dir) ? DXT_KIND_DIRECT :
                (is32 && bit_pag) ? DXT_KIND_PAGED  :
                wide_ok           ? DXT_KIND_WIDE   :
                                    DXT_KIND_BAD;

  // Entry index selection by page size
  wire [TE_IDX_W-1:0] idx4k  = req.addr[PAGE_HI:OFF4K_W];
  wire [TE_IDX_W-1:0] idx16k =
    {2'b00, req.addr[PAGE_HI:OFF16K_W]};
  assign te_index = page_16k ? idx16k : idx4k;

  // ----------------------------------------------------------------------
  // System address formation
  // ----------------------------------------------------------------------
  wire [SYS_ADDR_W-1:0] dir_addr =
    {2'b00, dmap_q, req.addr[DIRECT_LO_W-1:0]};
  // Page frame from the entry; offset width follows the page size.
  wire [SYS_ADDR_W-1:0] pfn_base = {te_data.pfn, 14'h0000};
  wire [SYS_ADDR_W-1:0] pag_addr = page_16k ?
    {pfn_base[SYS_ADDR_W-1:OFF16K_W], req.addr[OFF16K_W-1:0]} :
    {te_data.pfn, 2'b00, req.addr[OFF4K_W-1:0]};
  wire [SYS_ADDR_W-1:0] wid_addr =
    req.addr[SYS_ADDR_W-1:0];
  wire [ATTR_W-1:0] pag_attr = te_data.attr | {dmap_q[ATTR_W-1:0]};
  wire [ATTR_W-1:0] dir_attr = dev_attr | {dmap_q[ATTR_W-1:0]};
  wire              unused_wide_hi = req.addr[WIDE_TGT_W-1] ^ no_dac;

  dxt_out_t nxt;
  always_comb begin
    nxt        = '0;
    nxt.kind   = kind;
    nxt.wr     = req.wr;
    unique case (kind)
      DXT_KIND_DIRECT: begin
        nxt.sys_addr = dir_addr;
        nxt.attr     = dir_attr;
      end
      DXT_KIND_PAGED: begin
        nxt.sys_addr = pag_addr;
        nxt.attr     = pag_attr;
      end
      DXT_KIND_WIDE: begin
        nxt.sys_addr = wid_addr;
        nxt.attr     = req.addr[ATTR_HI:ATTR_LO];
      end
      DXT_KIND_BAD: begin
        nxt.sys_addr = '0;
        nxt.attr     = '0;
      end
    endcase
    nxt.remote =
      (nxt.sys_addr[NODE_LSB +: NODE_W] != local_node);
  end

  // ----------------------------------------------------------------------
  // Output stage and posted write tracking
  // ----------------------------------------------------------------------
  logic                         out_valid_q;
  dxt_out_t                     out_q;
  logic [$clog2(POST_DEPTH+1)-1:0] posted_q;
  logic                         irq_pend_q;
  logic                         cpu_irq_q;
  logic                         err_q;
  logic                         wide_err_q;

  // Writes held in the bridge stall new writes once the post count is full
  wire post_full = (posted_q == POST_DEPTH[$bits(posted_q)-1:0]);
  // A pending interrupt blocks new requests so it only waits on older writes
  wire out_free  = !out_valid_q || hub_ready;
  assign req_ready = out_free && !irq_pend_q && !(req.wr && post_full);

  wire take     = req_valid && req_ready;
  wire take_ok  = take && (kind != DXT_KIND_BAD);
  wire hub_fire = out_valid_q && hub_ready;
  wire post_inc = hub_fire && out_q.wr;
  wire post_dec = hub_wr_done && (posted_q != '0);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      out_q       <= '0;
    end else if (out_free) begin
      out_valid_q <= take_ok;
      if (take_ok) out_q <= nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) posted_q <= '0;
    else posted_q <= posted_q + $bits(posted_q)'(post_inc)
                              - $bits(posted_q)'(post_dec);
  end

  // Interrupt held until every posted write, and the one in flight, is done
  wire drained = (posted_q == '0) && !out_valid_q && !hub_wr_done;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_pend_q <= 1'b0;
      cpu_irq_q  <= 1'b0;
    end else begin
      cpu_irq_q <= 1'b0;
      if (dev_irq) irq_pend_q <= 1'b1;
      else if (irq_pend_q && drained) begin
        irq_pend_q <= 1'b0;
        cpu_irq_q  <= 1'b1;
      end
    end
  end
  assign cpu_irq = cpu_irq_q;

  // Sticky-free one-cycle error pulses for discarded requests and attribute fields sent without dac
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_q      <= 1'b0;
      wide_err_q <= 1'b0;
    end else begin
      err_q      <= take && (kind == DXT_KIND_BAD);
      wide_err_q <= take && !req.dac && wide_attr && !upper_zero;
    end
  end
  assign xlate_err       = err_q;
  assign wide_no_dac_err = wide_err_q ^ (unused_wide_hi & 1'b0);

  // Consistent mappings are always given 32-bit addresses by software; the
  // translator honours the address kind presented and needs no mode here.
  wire unused_cons = req.consistent;
  // Cache coherence is handled by the hub; nothing to synchronise.

  assign hub_valid = out_valid_q;
  assign hub_req   = out_q;

endmodule : dxt_translator

// ===== dv/dxt_translator_monitor.sv
// Port checker for the DMA address translator
`timescale 1ns/1ps
module dxt_translator_monitor
  import dxt_pkg::*;
(
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic             req_valid,
  input wire logic             req_ready,
  input wire dxt_req_t         req,
  input wire logic [16:0]      dmap_value,
  input wire logic             dmap_load,
  input wire logic             page_16k,
  input wire logic [11:0]      local_node,
  input wire logic [17:0]      te_index,
  input wire logic             hub_valid,
  input wire logic             hub_ready,
  input wire dxt_out_t         hub_req,
  input wire logic             xlate_err,
  input wire logic [16:0]      dmap_q_out
);
  wire tk  = req_valid && req_ready;
  wire single_cycle_addressing = !req.dac || req.addr[63:32] == 32'h0;
  wire bad = single_cycle_addressing && !req.addr[31] && !req.addr[30];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_dir;
    tk && single_cycle_addressing && req.addr[31] |=> hub_valid && hub_req.kind == DXT_KIND_DIRECT
      && hub_req.sys_addr[30:0] == $past(req.addr[30:0])
      && hub_req.sys_addr[47:31] == dmap_q_out;
  endproperty
  a_dir: assert property (p_dir) else $error("direct bad");
  property p_pag;
    tk && single_cycle_addressing && req.addr[31:30] == 2'h1 |=> hub_req.kind == DXT_KIND_PAGED;
  endproperty
  a_pag: assert property (p_pag) else $error("paged bad");
  property p_i4;
    tk && single_cycle_addressing && !page_16k |-> te_index == req.addr[29:12];
  endproperty
  a_i4: assert property (p_i4) else $error("index 4k");
  property p_i16;
    tk && single_cycle_addressing && page_16k |-> te_index == {2'h0, req.addr[29:14]};
  endproperty
  a_i16: assert property (p_i16) else $error("index 16k");
  property p_wid;
    tk && !single_cycle_addressing && req.addr[63:54] == ATTR_ALL_SET |=> hub_valid
      && hub_req.kind == DXT_KIND_WIDE
      && hub_req.sys_addr == $past(req.addr[49:0]);
  endproperty
  a_wid: assert property (p_wid) else $error("wide bad");
  property p_err;
    tk && bad |=> xlate_err && !hub_valid;
  endproperty
  a_err: assert property (p_err) else $error("no error");
  property p_rem;
    hub_valid |-> hub_req.remote == (hub_req.sys_addr[49:38] != local_node);
  endproperty
  a_rem: assert property (p_rem) else $error("remote bad");
  property p_dm;
    dmap_load |=> dmap_q_out == $past(dmap_value);
  endproperty
  a_dm: assert property (p_dm) else $error("dmap bad");
  property p_hold;
    hub_valid && !hub_ready |=> hub_valid && $stable(hub_req);
  endproperty
  a_hold: assert property (p_hold) else $error("hub dropped");
  c_bad: cover property (tk && bad);
  c_p16: cover property (tk && page_16k && !bad);
  c_stall: cover property (hub_valid && !hub_ready);
endmodule : dxt_translator_monitor
bind dxt_translator dxt_translator_monitor mon (.*);

// ===== dv/dxt_dev_model.sv
// Requester model: DMA requests and device interrupts
`timescale 1ns/1ps
module dxt_dev_model
  import dxt_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     req_ready,
  output dxt_req_t      req,
  output logic          req_valid,
  output logic          dev_irq
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    dev_irq = 1'b0;
  end
  // Wide addresses only ever go out with dac set, unless told otherwise
  task automatic send(input logic [63:0] a, input logic w, input logic d);
    req_valid <= 1'b1;
    req <= '{addr: a, dac: d, wr: w, consistent: ~d};
    @(posedge clk);
    while (req_ready !== 1'b1) @(posedge clk);
  endtask : send
  // Released bus shows inverted data, not a stale copy
  task automatic idle();
    req_valid <= 1'b0;
    req <= ~req;
  endtask : idle
  task automatic irq();
    dev_irq <= 1'b1;
    @(posedge clk);
    dev_irq <= 1'b0;
  endtask : irq
endmodule : dxt_dev_model

// ===== dv/dxt_translator_tb_top.sv
// Self-checking testbench for the DMA address translator
`timescale 1ns/1ps
module dxt_translator_tb_top;
  import dxt_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, hub_ready = 1'b1, hub_wr_done = 1'b0;
  logic dmap_load = 1'b0, page_16k = 1'b0, hub_chk = 1'b1, dac;
  logic req_ready, req_valid, dev_irq, hub_valid, cpu_irq, xlate_err;
  logic wide_no_dac_err;
  logic [16:0] dmap_value = '0, dmap_q_out, xdm;
  logic [9:0]  dev_attr = 10'h0a5;
  logic [11:0] local_node = 12'h003;
  logic [17:0] te_index;
  logic [63:0] a;
  dxt_req_t    req;
  dxt_out_t    hub_req;
  dxt_out_t    exp_q[$];
  int errors = 0, num_checks = 0, n_xe = 0, n_wd = 0, n_irq = 0, x_xe = 0;
  wire dxt_te_t te_data = '{pfn: {te_index ^ 18'h2a5a5, te_index},
                            attr: te_index[9:0]};
  dxt_translator dut (.*);
  dxt_dev_model  dev (.*);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    hub_ready <= ($urandom % 4) != 0;
    n_xe += xlate_err;
    n_wd += wide_no_dac_err;
    n_irq += cpu_irq;
    if (hub_valid === 1'b1 && hub_ready && hub_chk) begin
      if (exp_q.size() == 0) cmp("hub_req", '0, hub_req);
      else cmp("hub_req", exp_q.pop_front(), hub_req);
    end
  end
  task automatic cmp(input string n, input logic [66:0] e, input logic [66:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : cmp
  function automatic dxt_out_t model(input logic [63:0] a, input logic w);
    dxt_out_t o;
    logic [17:0] ix;
    logic [35:0] pfn;
    ix = page_16k ? {2'h0, a[29:14]} : a[29:12];
    pfn = {ix ^ 18'h2a5a5, ix};
    o = '0;
    o.wr = w;
    if (a[63:32] != 32'h0) begin
      o = '{a[49:0], a[63:54], 1'b0, w, DXT_KIND_WIDE};
    end else if (a[31]) begin
      o = '{{2'h0, xdm, a[30:0]}, dev_attr | xdm[9:0], 1'b0, w,
            DXT_KIND_DIRECT};
    end else begin
      o.sys_addr = page_16k ? {pfn, a[13:0]} : {pfn, 2'h0, a[11:0]};
      o.attr = ix[9:0] | xdm[9:0];
      o.kind = DXT_KIND_PAGED;
    end
    o.remote = o.sys_addr[49:38] != local_node;
    return o;
  endfunction : model
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hfb35));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    xdm = 17'($urandom);
    dmap_value <= xdm;
    local_node <= {2'h0, xdm[16:7]};
    dmap_load <= 1'b1;
    @(posedge clk);
    dmap_load <= 1'b0;
    @(posedge clk);
    cmp("dmap_q_out", xdm, dmap_q_out);
    for (int p = 0; p < 2; p++) begin
      page_16k <= p[0];
      @(posedge clk);
      for (int i = 0; i < 24; i++) begin
        a = {$urandom, $urandom};
        case (i % 4)
          0: a[63:31] = 33'h1;
          1: a[63:30] = 34'h1;
          2: a[63:54] = ATTR_ALL_SET;
          default: a[63:30] = 34'h0;
        endcase
        dac = (i % 4 == 2) || (i % 8 == 4);
        if (i % 4 == 3) x_xe++;
        else exp_q.push_back(model(a, 1'b0));
        dev.send(a, 1'b0, dac);
      end
      dev.idle();
      for (int t = 0; t < 200 && exp_q.size() != 0; t++) @(posedge clk);
      // The last error pulse is only counted on the edge after it stands
      repeat (2) @(posedge clk);
    end
    cmp("xlate_err", x_xe, n_xe);
    exp_q.push_back(model(64'h8000_0040, 1'b1));
    dev.send(64'h8000_0040, 1'b1, 1'b0);
    dev.idle();
    dev.irq();
    repeat (8) @(posedge clk);
    cmp("cpu_irq", 0, n_irq);
    hub_wr_done <= 1'b1;
    @(posedge clk);
    hub_wr_done <= 1'b0;
    repeat (8) @(posedge clk);
    cmp("cpu_irq", 1, n_irq);
    cmp("queue", 0, exp_q.size());
    hub_chk <= 1'b0;
    // Attribute field set but sent in a single cycle: refused and flagged
    dev.send(64'hffc0_0001_0000_0000, 1'b0, 1'b0);
    dev.idle();
    repeat (4) @(posedge clk);
    cmp("wide_no_dac_err", 1, n_wd);
    finish_test();
  end
endmodule : dxt_translator_tb_top
